// ---- core/cpb_context_builder.sv ----
// context packet builder: APB register slave plus a 32-bit word stream
// of standard-flow and version-flow context packets.
// assumes the sink runs on clk_i; lock inputs come from pins.
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module cpb_context_builder #(
    parameter int unsigned LOCK_CYC = cpb_pkg::LOCK_CYC,
    parameter int unsigned TICK_CYC = cpb_pkg::TICK_CYC
)(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [31:0] ts_int_i,
    input  wire logic [63:0] ts_frac_i,
    input  wire logic        lock_time_i,
    input  wire logic        lock_freq_i,
    input  wire logic        pkt_ready_i,
    output logic      [31:0] pkt_data_o,
    output logic             pkt_valid_o,
    output logic             pkt_last_o
);
    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SEND = 2'b10} cpb_state_e;

    // keep a declared sample size inside the legal range
    function automatic logic [5:0] clamp_depth(input logic [5:0] v);
        if (v < cpb_pkg::DEPTH_MIN)
            return cpb_pkg::DEPTH_MIN;
        if (v > cpb_pkg::DEPTH_MAX)
            return cpb_pkg::DEPTH_MAX;
        return v;
    endfunction

    // address decode for the error answer; the read mux decodes paddr_i itself
    function automatic logic addr_ok(input logic [7:0] a);
        return (a <= cpb_pkg::A_STAT) && (a[1:0] == 2'b00);
    endfunction

    cpb_state_e  st_q;
    logic        en_q;
    logic [4:0]  rate_q;
    logic        vreq_q;
    logic [31:0] sid_q;
    logic [63:0] srate_q;
    logic [63:0] tsadj_q;
    logic [31:0] calt_q;
    logic [5:0]  pack_q;
    logic [5:0]  item_q;
    logic [31:0] build_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [1:0]  tl_sync_q;
    logic [1:0]  fl_sync_q;
    logic        tl_rep_q;
    logic        fl_rep_q;
    logic [31:0] lock_cnt_q;
    logic [31:0] tick_cnt_q;
    logic [5:0]  acc_q;
    logic        per_q;
    logic        chg_q;
    logic        chg_snap_q;
    logic        ver_q;
    logic [3:0]  seq_q;
    logic [4:0]  idx_q;
    logic [4:0]  cur_q;
    logic [4:0]  len_q;
    logic [31:0] tsi_q;
    logic [63:0] tsf_q;
    logic [31:0] data_q;
    logic        valid_q;
    logic        last_q;
    logic        ver_pend_q;
    logic        setup;
    logic        wr;
    logic        lock_tick;
    logic        rep_chg;
    logic        chg_set;
    logic        start;
    logic        start_ver;
    logic        adv;
    logic [31:0] rd_d;
    logic [31:0] word_d;
    logic [31:0] hdr_d;

    assign setup = psel_i & ~penable_i;
    assign wr    = psel_i & penable_i & pwrite_i & pready_q;
    assign adv   = ~valid_q | pkt_ready_i;

    // read mux, evaluated in the setup cycle
    always_comb
    begin
        case (paddr_i)
            cpb_pkg::A_CTRL:     rd_d = {26'h000_0000, rate_q, en_q};
            cpb_pkg::A_SID:      rd_d = sid_q;
            cpb_pkg::A_SRATE_HI: rd_d = srate_q[63:32];
            cpb_pkg::A_SRATE_LO: rd_d = srate_q[31:0];
            cpb_pkg::A_TSADJ_HI: rd_d = tsadj_q[63:32];
            cpb_pkg::A_TSADJ_LO: rd_d = tsadj_q[31:0];
            cpb_pkg::A_CALT:     rd_d = calt_q;
            cpb_pkg::A_FMT:      rd_d = {20'h0_0000, pack_q, item_q};
            cpb_pkg::A_BUILD:    rd_d = build_q;
            cpb_pkg::A_STAT:     rd_d = {23'h00_0000, ver_pend_q, chg_q,
                                         valid_q, fl_rep_q, tl_rep_q, seq_q};
            default:             rd_d = 32'h0000_0000;
        endcase
    end

    // APB answer: zero wait states, error on unmapped word
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= setup;
            pslverr_q <= setup & ~addr_ok(paddr_i);
            prdata_q  <= setup ? rd_d : prdata_q;
        end
    end

    // a context write that changes a stored value counts as a change
    always_comb
    begin
        chg_set = rep_chg;
        if (wr)
        begin
            case (paddr_i)
                cpb_pkg::A_SID:      chg_set = chg_set | (pwdata_i != sid_q);
                cpb_pkg::A_SRATE_HI: chg_set = chg_set | (pwdata_i != srate_q[63:32]);
                cpb_pkg::A_SRATE_LO: chg_set = chg_set | (pwdata_i != srate_q[31:0]);
                cpb_pkg::A_TSADJ_HI: chg_set = chg_set | (pwdata_i != tsadj_q[63:32]);
                cpb_pkg::A_TSADJ_LO: chg_set = chg_set | (pwdata_i != tsadj_q[31:0]);
                cpb_pkg::A_CALT:     chg_set = chg_set | (pwdata_i != calt_q);
                cpb_pkg::A_FMT:      chg_set = chg_set
                                       | (clamp_depth(pwdata_i[11:6]) != pack_q)
                                       | (clamp_depth(pwdata_i[5:0]) != item_q);
                default:             chg_set = chg_set;
            endcase
        end
    end

    // configuration registers
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            en_q    <= 1'b0;
            rate_q  <= 5'h00;
            vreq_q  <= 1'b0;
            sid_q   <= 32'h0000_0000;
            srate_q <= 64'h0000_0000_0000_0000;
            tsadj_q <= 64'h0000_0000_0000_0000;
            calt_q  <= 32'h0000_0000;
            pack_q  <= cpb_pkg::DEPTH_RST;
            item_q  <= cpb_pkg::DEPTH_RST;
            build_q <= 32'h0000_0000;
        end
        else
        begin
            vreq_q <= wr && paddr_i == cpb_pkg::A_CTRL
                      && pwdata_i[cpb_pkg::CTRL_VREQ_BIT];
            if (wr)
            begin
                case (paddr_i)
                    cpb_pkg::A_CTRL:
                    begin
                        en_q   <= pwdata_i[cpb_pkg::CTRL_EN_BIT];
                        rate_q <= (pwdata_i[5:1] > cpb_pkg::RATE_MAX)
                                  ? cpb_pkg::RATE_MAX : pwdata_i[5:1];
                    end
                    cpb_pkg::A_SID:      sid_q <= pwdata_i;
                    cpb_pkg::A_SRATE_HI: srate_q[63:32] <= pwdata_i;
                    cpb_pkg::A_SRATE_LO: srate_q[31:0] <= pwdata_i;
                    cpb_pkg::A_TSADJ_HI: tsadj_q[63:32] <= pwdata_i;
                    cpb_pkg::A_TSADJ_LO: tsadj_q[31:0] <= pwdata_i;
                    cpb_pkg::A_CALT:     calt_q <= pwdata_i;
                    cpb_pkg::A_FMT:
                    begin
                        pack_q <= clamp_depth(pwdata_i[11:6]);
                        item_q <= clamp_depth(pwdata_i[5:0]);
                    end
                    cpb_pkg::A_BUILD:    build_q <= pwdata_i;
                    default:             en_q <= en_q;
                endcase
            end
        end
    end

    // lock pins: two-stage synchronisers, reported once per second
    assign lock_tick = lock_cnt_q == 32'(LOCK_CYC - 1);
    assign rep_chg   = lock_tick & ((tl_sync_q[1] != tl_rep_q)
                                  | (fl_sync_q[1] != fl_rep_q));
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            tl_sync_q  <= 2'b00;
            fl_sync_q  <= 2'b00;
            tl_rep_q   <= 1'b0;
            fl_rep_q   <= 1'b0;
            lock_cnt_q <= 32'h0000_0000;
        end
        else
        begin
            tl_sync_q  <= {tl_sync_q[0], lock_time_i};
            fl_sync_q  <= {fl_sync_q[0], lock_freq_i};
            lock_cnt_q <= lock_tick ? 32'h0000_0000 : lock_cnt_q + 32'h0000_0001;
            if (lock_tick)
            begin
                tl_rep_q <= tl_sync_q[1];
                fl_rep_q <= fl_sync_q[1];
            end
        end
    end

    // periodic pacing: rate added per 1/20 s tick, packet per 20 counted
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            tick_cnt_q <= 32'h0000_0000;
            acc_q      <= 6'h00;
            per_q      <= 1'b0;
        end
        else
        begin
            if (tick_cnt_q == 32'(TICK_CYC - 1))
            begin
                tick_cnt_q <= 32'h0000_0000;
                if (acc_q + {1'b0, rate_q} >= {1'b0, cpb_pkg::RATE_MAX})
                begin
                    acc_q <= acc_q + {1'b0, rate_q} - {1'b0, cpb_pkg::RATE_MAX};
                    per_q <= en_q;
                end
                else
                begin
                    acc_q <= acc_q + {1'b0, rate_q};
                    if (start && !start_ver)
                        per_q <= 1'b0; // no new due: a started standard packet clears it
                end
            end
            else
            begin
                tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
                if (start && !start_ver)
                    per_q <= 1'b0;
            end
        end
    end

    // packet start arbitration: version request first
    assign start     = st_q == ST_IDLE && (ver_pend_q || (en_q && (chg_q || per_q)));
    assign start_ver = ver_pend_q;

    // change and version flags; a new event wins over the clear
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            chg_q      <= 1'b0;
            ver_pend_q <= 1'b0;
        end
        else
        begin
            chg_q      <= (chg_q & ~(start & ~start_ver)) | chg_set;
            ver_pend_q <= (ver_pend_q & ~start) | vreq_q;
        end
    end

    // header word for the packet being sent
    assign hdr_d = {cpb_pkg::HDR_TYPE, 1'b1, 2'b00, 1'b1,
                    cpb_pkg::HDR_TSI, cpb_pkg::HDR_TSF, seq_q,
                    ver_q ? cpb_pkg::LEN_VER : cpb_pkg::LEN_STD};

    // word mux by position in the packet
    always_comb
    begin
        case (idx_q)
            5'd0:    word_d = hdr_d;
            5'd1:    word_d = sid_q;
            5'd2:    word_d = {8'h00, cpb_pkg::OUI};
            5'd3:    word_d = {cpb_pkg::INFO_CLASS, ver_q ? cpb_pkg::PCLS_VER
                                                           : cpb_pkg::PCLS_STD};
            5'd4:    word_d = tsi_q;
            5'd5:    word_d = tsf_q[63:32];
            5'd6:    word_d = tsf_q[31:0];
            5'd7:    word_d = {chg_snap_q, 31'h0000_0000}
                              | (ver_q ? cpb_pkg::CIF0_VER : cpb_pkg::CIF0_STD);
            5'd8:    word_d = ver_q ? cpb_pkg::CIF1_VER : cpb_pkg::GAIN_WORD;
            5'd9:    word_d = ver_q ? cpb_pkg::SPEC_VER : srate_q[63:32];
            5'd10:   word_d = ver_q ? build_q : srate_q[31:0];
            5'd11:   word_d = tsadj_q[63:32];
            5'd12:   word_d = tsadj_q[31:0];
            5'd13:   word_d = calt_q;
            5'd14:   word_d = 32'({tl_rep_q, 1'b0, fl_rep_q})
                              << cpb_pkg::SE_FLOCK_BIT;
            5'd15:   word_d = {cpb_pkg::FMT_TOP, 12'h000, pack_q - 6'h01,
                               item_q - 6'h01};
            default: word_d = 32'h0000_0000;
        endcase
    end

    // packet sequencer and output stream register
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st_q       <= ST_IDLE;
            ver_q      <= 1'b0;
            chg_snap_q <= 1'b0;
            seq_q      <= 4'h0;
            idx_q      <= 5'd0;
            cur_q      <= 5'd0;
            len_q      <= 5'd0;
            tsi_q      <= 32'h0000_0000;
            tsf_q      <= 64'h0000_0000_0000_0000;
            data_q     <= 32'h0000_0000;
            valid_q    <= 1'b0;
            last_q     <= 1'b0;
        end
        else
        begin
            case (st_q)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        st_q       <= ST_SEND;
                        ver_q      <= start_ver;
                        len_q      <= start_ver ? cpb_pkg::LEN_VER[4:0]
                                                : cpb_pkg::LEN_STD[4:0];
                        chg_snap_q <= chg_q;
                        tsi_q      <= ts_int_i;
                        tsf_q      <= ts_frac_i;
                        idx_q      <= 5'd0;
                    end
                end
                ST_SEND:
                begin
                    if (adv)
                    begin
                        if (idx_q == len_q)
                        begin
                            valid_q <= 1'b0;
                            last_q  <= 1'b0;
                            seq_q   <= seq_q + 4'h1;
                            st_q    <= ST_IDLE;
                        end
                        else
                        begin
                            data_q  <= word_d;
                            valid_q <= 1'b1;
                            cur_q   <= idx_q;
                            last_q  <= idx_q == len_q - 5'd1;
                            idx_q   <= idx_q + 5'd1;
                        end
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    assign prdata_o    = prdata_q;
    assign pready_o    = pready_q;
    assign pslverr_o   = pslverr_q;
    assign pkt_data_o  = data_q;
    assign pkt_valid_o = valid_q;
    assign pkt_last_o  = last_q;

    // checks on emitted words, the rate register and the change flag
    property p_gain_zero;
        @(posedge clk_i) disable iff (reset_i)
        valid_q && !ver_q && cur_q == 5'd8 |-> data_q == 32'h0000_0000;
    endproperty
    a_gain_zero: assert property (p_gain_zero) else $error("gain word not zero");

    property p_locks;
        @(posedge clk_i) disable iff (reset_i)
        valid_q && !ver_q && cur_q == 5'd14
        |-> data_q[19] == tl_rep_q && data_q[17] == fl_rep_q;
    endproperty
    a_locks: assert property (p_locks) else $error("lock bits wrong");

    property p_fmt;
        @(posedge clk_i) disable iff (reset_i)
        valid_q && !ver_q && cur_q == 5'd15 |-> data_q[31:12] == 20'hA_0000
        && data_q[5:0] >= 6'd3 && data_q[5:0] <= 6'd15;
    endproperty
    a_fmt: assert property (p_fmt) else $error("payload format word wrong");

    property p_rate;
        @(posedge clk_i) disable iff (reset_i)
        wr && paddr_i == 8'h00 |=> rate_q <= 5'd20;
    endproperty
    a_rate: assert property (p_rate) else $error("rate above twenty");

    property p_hdr;
        @(posedge clk_i) disable iff (reset_i)
        valid_q && cur_q == 5'd0 |-> data_q[31:28] == 4'h4
        && data_q[26:25] == 2'b00 && data_q[24] && data_q[21:20] == 2'h2;
    endproperty
    a_hdr: assert property (p_hdr) else $error("header fixed bits wrong");

    property p_len;
        @(posedge clk_i) disable iff (reset_i)
        valid_q && ver_q && cur_q == 5'd0 |-> data_q[15:0] == 16'd11;
    endproperty
    a_len: assert property (p_len) else $error("version size not eleven");

    property p_vwords;
        @(posedge clk_i) disable iff (reset_i)
        valid_q && ver_q && (cur_q == 5'd8 || cur_q == 5'd9)
        |-> data_q == ((cur_q == 5'd8) ? 32'h0000_000C : 32'h0000_0004);
    endproperty
    a_vwords: assert property (p_vwords) else $error("version words wrong");

    property p_last;
        @(posedge clk_i) disable iff (reset_i)
        valid_q && last_q |-> cur_q == (ver_q ? 5'd10 : 5'd16);
    endproperty
    a_last: assert property (p_last) else $error("packet length wrong");

    property p_seq;
        @(posedge clk_i) disable iff (reset_i)
        valid_q && last_q && pkt_ready_i |=> ##1 seq_q == $past(seq_q, 2) + 4'h1;
    endproperty
    a_seq: assert property (p_seq) else $error("sequence did not step");

    property p_chg;
        @(posedge clk_i) disable iff (reset_i)
        chg_set |=> chg_q;
    endproperty
    a_chg: assert property (p_chg) else $error("change lost");
endmodule

`default_nettype wire

// ---- core/cpb_pkg.sv ----
// constants of the context packet builder: register map, field layout,
// fixed packet words and pacing counts.
// assumes a 125 MHz packet clock and an APB register port.
package cpb_pkg;
    // register byte offsets
    localparam logic [7:0] A_CTRL     = 8'h00;
    localparam logic [7:0] A_SID      = 8'h04;
    localparam logic [7:0] A_SRATE_HI = 8'h08;
    localparam logic [7:0] A_SRATE_LO = 8'h0C;
    localparam logic [7:0] A_TSADJ_HI = 8'h10;
    localparam logic [7:0] A_TSADJ_LO = 8'h14;
    localparam logic [7:0] A_CALT     = 8'h18;
    localparam logic [7:0] A_FMT      = 8'h1C;
    localparam logic [7:0] A_BUILD    = 8'h20;
    localparam logic [7:0] A_STAT     = 8'h24;
    // control register fields
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_RATE_LSB = 1;
    localparam int CTRL_VREQ_BIT = 8;
    // state and event indicator bits
    localparam int SE_TLOCK_BIT = 19;
    localparam int SE_FLOCK_BIT = 17;
    // header fields
    localparam logic [3:0]  HDR_TYPE   = 4'h4;
    localparam logic [1:0]  HDR_TSI    = 2'h1;
    localparam logic [1:0]  HDR_TSF    = 2'h2;
    localparam logic [15:0] LEN_VER    = 16'h000B;
    localparam logic [15:0] LEN_STD    = 16'h0011;
    // class words; the organisation code is arbitrary
    localparam logic [23:0] OUI        = 24'h00_0A5C;
    localparam logic [15:0] INFO_CLASS = 16'h0001;
    localparam logic [15:0] PCLS_VER   = 16'h0004;
    localparam logic [15:0] PCLS_STD   = 16'h0001;
    // indicator and version words
    localparam logic [31:0] CIF0_VER   = 32'h0000_0002;
    localparam logic [31:0] CIF0_STD   = 32'h00B9_8000;
    localparam logic [31:0] CIF1_VER   = 32'h0000_000C;
    localparam logic [31:0] SPEC_VER   = 32'h0000_0004;
    localparam logic [31:0] GAIN_WORD  = 32'h0000_0000;
    localparam logic [7:0]  FMT_TOP    = 8'hA0;
    // sample component size limits and rate ceiling
    localparam logic [5:0]  DEPTH_MIN  = 6'h04;
    localparam logic [5:0]  DEPTH_MAX  = 6'h10;
    localparam logic [5:0]  DEPTH_RST  = 6'h10;
    localparam logic [4:0]  RATE_MAX   = 5'h14;
    // pacing: lock report period and periodic rate base tick
    localparam int unsigned LOCK_PERIOD_MS = 1000;
    localparam int unsigned CLK_MHZ        = 125;
    localparam int unsigned LOCK_CYC = LOCK_PERIOD_MS * CLK_MHZ * 1000;
    localparam int unsigned TICK_CYC = LOCK_CYC / 20;
endpackage

// ---- verification/cpb_sink_model.sv ----
// sink model: takes context packet words, may stall, keeps lock state
// assumes it shares clk_i and reset_i with the builder
`timescale 1ns/1ps
`default_nettype none
module cpb_sink_model (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        slow_i,
    input  wire logic [31:0] pkt_data_i,
    input  wire logic        pkt_valid_i,
    input  wire logic        pkt_last_i,
    output logic             pkt_ready_o
);
    logic [31:0] words[$];
    logic        lasts[$];
    logic [4:0]  idx_q;
    logic        tlock_q;
    logic        delay_ok;
    // measured and network delay usable only while time lock is seen
    assign delay_ok = tlock_q;
    // ready drops every other cycle when slow
    always_ff @(posedge clk_i or posedge reset_i)
        if (reset_i)
            pkt_ready_o <= 1'b0;
        else
            pkt_ready_o <= !slow_i || !pkt_ready_o;
    // capture words; the gain word is never interpreted
    always @(posedge clk_i)
    begin
        if (reset_i)
        begin
            idx_q <= 5'd0;
            tlock_q <= 1'b0;
        end
        else if (pkt_valid_i && pkt_ready_o)
        begin
            words.push_back(pkt_data_i);
            lasts.push_back(pkt_last_i);
            idx_q <= pkt_last_i ? 5'd0 : idx_q + 5'd1;
            if (idx_q == 5'd14)
                tlock_q <= pkt_data_i[19];
        end
    end
endmodule
`default_nettype wire

// ---- verification/test_context_packet_builder.sv ----
// testbench of the context packet builder with the sink model
// assumes short pacing counts: lock period 200, tick 10 cycles
`timescale 1ns/1ps
`default_nettype none
module test_context_packet_builder;
    logic        clk_i, reset_i, psel, pen, pwr, slow, lt, lf, rdy, pv, pl, er;
    logic [7:0]  pa;
    logic [31:0] pwd, prd, rd, pd;
    logic        pready, perr;
    logic [3:0]  seq;
    int          failures, compares, cyc, wt;
    cpb_context_builder #(.LOCK_CYC(200), .TICK_CYC(10)) u_dut (
        .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
        .pready_o(pready), .pslverr_o(perr), .ts_int_i(32'h0000_1234),
        .ts_frac_i(64'h0000_0000_0000_5678), .lock_time_i(lt),
        .lock_freq_i(lf), .pkt_ready_i(rdy), .pkt_data_o(pd),
        .pkt_valid_o(pv), .pkt_last_o(pl));
    cpb_sink_model u_sink (.clk_i(clk_i), .reset_i(reset_i), .slow_i(slow),
        .pkt_data_i(pd), .pkt_valid_i(pv), .pkt_last_i(pl), .pkt_ready_o(rdy));
    // compare and count
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            failures++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    // one apb transfer, waits for pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk_i);
        pen <= 1'b1;
        do
            @(posedge clk_i);
        while (pready !== 1'b1);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    function automatic logic [31:0] w(input int i);
        return u_sink.words[i];
    endfunction
    task automatic clr();
        u_sink.words.delete();
        u_sink.lasts.delete();
    endtask
    // wait for a packet of n words and check its framing
    task automatic pkt(input int n);
        wt = 0;
        while (u_sink.words.size() < n && wt < 3000)
        begin
            @(posedge clk_i);
            wt++;
        end
        repeat (3) @(posedge clk_i);
        check("words", 32'(u_sink.words.size()), 32'(n));
        check("last", 32'(u_sink.lasts[n-1]), 32'h1);
        check("hdr", w(0), {8'h49, 4'h6, seq, 16'(n)});
        seq++;
    endtask
    task automatic t_version();
        apb(1, cpb_pkg::A_BUILD, 32'h1A2B_0041);
        apb(1, cpb_pkg::A_SID, 32'h0000_00A5);
        apb(1, cpb_pkg::A_CTRL, 32'h0000_0100);
        pkt(11);
        check("sid", w(1), 32'h0000_00A5);
        check("oui", w(2), {8'h00, cpb_pkg::OUI});
        check("class", w(3), 32'h0001_0004);
        check("tsi", w(4), 32'h0000_1234);
        check("tsf", w(6), 32'h0000_5678);
        check("cif0", w(7), 32'h8000_0002);
        check("cif1", w(8), 32'h0000_000C);
        check("spec", w(9), 32'h0000_0004);
        check("build", w(10), 32'h1A2B_0041);
        repeat (17)
        begin
            clr();
            apb(1, cpb_pkg::A_CTRL, 32'h0000_0100);
            pkt(11);
        end
    endtask
    task automatic t_standard();
        apb(1, cpb_pkg::A_TSADJ_HI, 32'hFFFF_FFFF);
        apb(1, cpb_pkg::A_TSADJ_LO, 32'hFFFF_FC18);
        apb(1, cpb_pkg::A_CALT, 32'h0000_1200);
        clr();
        apb(1, cpb_pkg::A_CTRL, 32'h0000_0001);
        pkt(17);
        check("cif0", w(7), 32'h80B9_8000);
        check("gain", w(8), 32'h0000_0000);
        check("adj", w(12), 32'hFFFF_FC18);
        check("cal", w(13), 32'h0000_1200);
        check("state", w(14) & 32'h000A_0000, 32'h0000_0000);
        check("fmt", w(15) & 32'h0000_0FFF, 32'h0000_03CF);
        check("fmt1", w(16), 32'h0000_0000);
        clr();
        slow <= 1'b1;
        apb(1, cpb_pkg::A_FMT, {20'h0, 6'd12, 6'd3});
        pkt(17);
        check("fmt", w(15) & 32'h0000_0FFF, {20'h0, 6'd11, 6'd3});
        apb(0, cpb_pkg::A_FMT, 32'h0);
        check("fmtrd", rd & 32'h0000_0FFF, {20'h0, 6'd12, 6'd4});
        clr();
        repeat (300) @(posedge clk_i);
        check("quiet", 32'(u_sink.words.size()), 32'h0);
    endtask
    task automatic t_lock();
        clr();
        lt <= 1'b1;
        pkt(17);
        check("lockwait", 32'(wt <= 450), 32'h1);
        check("tlock", w(14) & 32'h000A_0000, 32'h0008_0000);
        clr();
        lf <= 1'b1;
        pkt(17);
        check("flock", w(14) & 32'h000A_0000, 32'h000A_0000);
    endtask
    task automatic t_rate();
        int n;
        apb(1, cpb_pkg::A_CTRL, 32'h0000_003F);
        apb(0, cpb_pkg::A_CTRL, 32'h0);
        check("rate", rd & 32'h0000_003E, 32'h0000_0028);
        apb(1, cpb_pkg::A_CTRL, 32'h0000_0003);
        repeat (100) @(posedge clk_i);
        clr();
        repeat (1000) @(posedge clk_i);
        n = 0;
        foreach (u_sink.lasts[i])
            n += int'(u_sink.lasts[i] === 1'b1);
        check("periodic", 32'(n >= 4 && n <= 6), 32'h1);
        apb(0, 8'h28, 32'h0);
        check("unmapped", {er, rd[30:0]}, 32'h8000_0000);
    endtask
    task automatic summarize();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // clock and hang guard
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            summarize();
        end
    end
    // main sequence
    initial
    begin
        {psel, pen, pwr, slow, lt, lf, pa, pwd, seq} = '0;
        {failures, compares, cyc} = '0;
        reset_i = 1'b1;
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        t_version();
        t_standard();
        t_lock();
        t_rate();
        summarize();
    end
endmodule
`default_nettype wire
